// ===== hdl/emb_bus_ctrl.sv
`timescale 1ns/1ps
// ======================================================================
// External multiplexed memory bus controller
// ======================================================================
module emb_bus_ctrl
   import emb_pkg::*;
(
   // Clock, reset, enable
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             clk_en_in,
   // Core request side
   input  wire logic             req_valid_in,
   input  wire emb_req_t         req_in,
   output logic                  req_ready_out,
   output logic                  rd_valid_out,
   output logic [15:0]           rd_data_out,
   // Configuration and power state
   input  wire emb_cfg_t         cfg_in,
   input  wire logic             sleep_in,
   input  wire logic             idle_in,
   // External bus pins
   input  wire logic [15:0]      mux_bus_in,
   output emb_pins_t             pins_out
);
   // ==================================================================
   // Declarations
   // ==================================================================
   typedef enum logic [1:0] {ST_IDLE, ST_CYCLE, ST_WAIT} emb_state_t;
   emb_state_t  state;
   logic [1:0]  phase;
   emb_req_t    cur;
   logic [15:0] bus_sync1;
   logic [15:0] bus_sync2;
   logic [7:0]  held_byte;
   logic        wait_busy;
   logic        frozen;
   logic        cycle_end;
   logic        word_mode;
   logic        bsel_mode;
   logic        even_capture;
   logic        wait_load;
   logic        next_rd_valid;
   logic        rd_step1;
   logic        rd_step2;
   logic [7:0]  rd_low_byte;
   emb_pins_t   next_pins;

   assign frozen    = sleep_in || idle_in;
   assign cycle_end = (state == ST_CYCLE) && (phase == PH_LAST);
   assign word_mode = !cfg_in.bus_8bit && (cfg_in.write_mode_select == WM_WORD_WRITE);
   assign bsel_mode = !cfg_in.bus_8bit && (cfg_in.write_mode_select == WM_BYTE_SELECT);
   // Frozen cycles must not recapture or reload while parked in the last phase
   assign even_capture = cycle_end && cur.is_write && word_mode && !cur.table_pointer[0]
                         && !frozen;
   assign wait_load = cycle_end && cfg_in.wait_enable && !frozen;
   assign req_ready_out = (state == ST_IDLE) && !frozen && !wait_busy;

   // ==================================================================
   // Helpers
   // ==================================================================
   emb_hold_latch u_hold (
      .clock_in   (clock_in),
      .rst_n_in   (rst_n_in),
      .clk_en_in  (clk_en_in),
      .capture_in (even_capture),
      .data_in    (cur.table_latch_byte),
      .held_out   (held_byte)
   );

   emb_wait_timer u_wait (
      .clock_in     (clock_in),
      .rst_n_in     (rst_n_in),
      .clk_en_in    (clk_en_in),
      .load_in      (wait_load),
      .count_in     (cfg_in.wait_state_count),
      .cycle_end_in (phase == PH_LAST && !frozen),
      .busy_out     (wait_busy)
   );

   // ==================================================================
   // Pin input synchroniser
   // ==================================================================
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         bus_sync1 <= ADDR_RESET;
         bus_sync2 <= ADDR_RESET;
      end
      else if (clk_en_in)
      begin
         bus_sync1 <= mux_bus_in;
         bus_sync2 <= bus_sync1;
      end
   end

   // ==================================================================
   // Phase counter, free running so wait states count instruction cycles
   // ==================================================================
   // Slow run modes only stretch clk_en_in; no other change needed
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
         phase <= PH_ADDR;
      else if (clk_en_in && !frozen)
         phase <= phase + 2'h1;
   end

   // ==================================================================
   // Access sequencer
   // ==================================================================
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         state <= ST_IDLE;
         cur   <= '0;
      end
      else if (clk_en_in && !frozen)
      begin
         unique case (state)
            ST_IDLE:
               if (req_valid_in && !wait_busy && phase == PH_LAST)
               begin
                  state <= ST_CYCLE;
                  cur   <= req_in;
               end
            ST_CYCLE:
               if (phase == PH_LAST)
                  state <= (cur.is_write || cfg_in.wait_enable) ? ST_WAIT : ST_IDLE;
            ST_WAIT:
               state <= ST_IDLE;
         endcase
      end
   end

   // ==================================================================
   // Pin values for this phase
   // ==================================================================
   always_comb
   begin
      next_pins = pins_out;
      next_rd_valid = 1'b0;
      if (frozen)
      begin
         // Everything else holds its entry state
         next_pins.chip_select_n       = 1'b1;
         next_pins.upper_byte_select_n = 1'b1;
         next_pins.lower_byte_select_n = 1'b1;
      end
      else if (state != ST_CYCLE)
      begin
         next_pins.mux_bus_oe          = 16'h0000;
         next_pins.addr_valid          = 1'b0;
         next_pins.chip_select_n       = 1'b1;
         next_pins.read_enable_n       = 1'b1;
         next_pins.write_high_strobe_n = 1'b1;
         next_pins.write_low_strobe_n  = 1'b1;
         next_pins.upper_byte_select_n = 1'b1;
         next_pins.lower_byte_select_n = 1'b1;
         next_pins.byte_address_lsb    = 1'b0;
      end
      else
      begin
         next_pins.chip_select_n    = 1'b0;
         next_pins.write_low_strobe_n = 1'b1;
         next_pins.byte_address_lsb = cur.table_pointer[0];
         next_pins.upper_byte_select_n = 1'b0;
         next_pins.lower_byte_select_n = 1'b0;
         if (bsel_mode && cur.is_write)
         begin
            next_pins.upper_byte_select_n = !cur.table_pointer[0];
            next_pins.lower_byte_select_n = cur.table_pointer[0];
         end
         next_pins.addr_valid    = (phase == PH_ADDR);
         next_pins.read_enable_n = 1'b1;
         next_pins.write_high_strobe_n = 1'b1;
         if (phase == PH_ADDR)
         begin
            next_pins.mux_bus_lines = cur.table_pointer;
            next_pins.mux_bus_oe    = 16'hffff;
         end
         else if (!cur.is_write)
         begin
            // Eight-bit: first byte, then toggle byte address for second
            next_pins.mux_bus_oe    = cfg_in.bus_8bit ? 16'hff00 : 16'h0000;
            next_pins.read_enable_n = 1'b0;
            if (cfg_in.bus_8bit)
               next_pins.byte_address_lsb = (phase != PH_DATA1);
            next_rd_valid = (phase == PH_LAST);
         end
         else if (even_capture || (word_mode && !cur.table_pointer[0]))
            next_pins.mux_bus_oe = 16'h0000;
         else
         begin
            next_pins.mux_bus_oe = 16'hffff;
            next_pins.mux_bus_lines[15:8] = cur.table_latch_byte;
            next_pins.mux_bus_lines[7:0]  = word_mode ? held_byte : cur.table_latch_byte;
            next_pins.write_high_strobe_n = (phase != PH_DATA2);
         end
      end
   end

   // ==================================================================
   // Output registers
   // ==================================================================
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         pins_out <= '{mux_bus_lines:ADDR_RESET, mux_bus_oe:16'h0000, addr_valid:1'b0,
                      chip_select_n:1'b1, read_enable_n:1'b1, write_high_strobe_n:1'b1,
                      write_low_strobe_n:1'b1, upper_byte_select_n:1'b1,
                      lower_byte_select_n:1'b1, byte_address_lsb:1'b0};
         rd_valid_out <= 1'b0;
         rd_data_out  <= ADDR_RESET;
         rd_step1     <= 1'b0;
         rd_step2     <= 1'b0;
         rd_low_byte  <= LATCH_RESET;
      end
      else if (clk_en_in)
      begin
         pins_out     <= next_pins;
         // Bus levels reach the second sync flop two cycles late, so the
         // first data phase is taken one cycle after the access ends
         rd_step1     <= next_rd_valid;
         rd_step2     <= rd_step1;
         rd_valid_out <= rd_step2;
         if (rd_step1)
            rd_low_byte <= bus_sync2[7:0];
         if (rd_step2)
            rd_data_out <= cfg_in.bus_8bit ? {bus_sync2[7:0], rd_low_byte} : bus_sync2;
      end
   end

   // ==================================================================
   // Checks
   // ==================================================================
   a_sleep_cs_high: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (clk_en_in && frozen) |=> pins_out.chip_select_n)
      else $error("chip select low while frozen");
   a_frozen_addr_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (clk_en_in && frozen && $past(frozen)) |=> $stable(pins_out.mux_bus_lines))
      else $error("bus lines moved while frozen");
   a_wrl_unused: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      pins_out.write_low_strobe_n)
      else $error("low strobe asserted");
   a_even_no_strobe: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (state == ST_CYCLE && cur.is_write && word_mode && !cur.table_pointer[0])
      |=> pins_out.write_high_strobe_n)
      else $error("strobe on even word write");
   a_cs_active: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (clk_en_in && state == ST_CYCLE && !frozen) |=> !pins_out.chip_select_n)
      else $error("chip select not asserted in access");
   a_ale_addr: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      pins_out.addr_valid |-> pins_out.mux_bus_oe == 16'hffff)
      else $error("address valid without address driven");
   a_odd_data: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (!pins_out.write_high_strobe_n && word_mode)
      |-> pins_out.mux_bus_lines[7:0] == held_byte)
      else $error("held byte missing on odd write");
   a_wait_ready: assert property (@(posedge clock_in) disable iff (!rst_n_in)
      (wait_busy && state == ST_IDLE) |=> state == ST_IDLE)
      else $error("access taken during wait states");
   c_word_pair: cover property (@(posedge clock_in) even_capture ##[1:40]
      !pins_out.write_high_strobe_n);
   c_read8: cover property (@(posedge clock_in) rd_valid_out && cfg_in.bus_8bit);
   c_sleep: cover property (@(posedge clock_in) frozen && !pins_out.chip_select_n ##1
      pins_out.chip_select_n);
endmodule // emb_bus_ctrl

// ===== hdl/emb_hold_latch.sv
`timescale 1ns/1ps
// ======================================================================
// Holding latch for the even byte of a word write
// ======================================================================
module emb_hold_latch
   import emb_pkg::*;
(
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             clk_en_in,
   // Capture
   input  wire logic             capture_in,
   input  wire logic [7:0]       data_in,
   // Held byte
   output logic [7:0]            held_out
);
   // Keeps its byte until the next capture
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
         held_out <= LATCH_RESET;
      else if (clk_en_in && capture_in)
         held_out <= data_in;
   end
endmodule // emb_hold_latch

// ===== hdl/emb_pkg.sv
package emb_pkg;
   // ==================================================================
   // Write modes and widths
   // ==================================================================
   localparam logic [1:0] WM_BYTE_WRITE  = 2'h0;
   localparam logic [1:0] WM_WORD_WRITE  = 2'h1;
   localparam logic [1:0] WM_BYTE_SELECT = 2'h2;
   localparam int         ADDR_W         = 16;
   localparam int         BYTE_W         = 8;
   localparam int         WAIT_W         = 2;
   localparam int         PHASE_W        = 2;
   // Quarter-cycle phases of one instruction cycle
   localparam logic [1:0] PH_ADDR        = 2'h0;
   localparam logic [1:0] PH_DATA1       = 2'h1;
   localparam logic [1:0] PH_DATA2       = 2'h2;
   localparam logic [1:0] PH_LAST        = 2'h3;
   localparam logic [7:0] LATCH_RESET    = 8'h00;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;

   // Access request from the core
   typedef struct packed {
      logic        is_write;
      logic [15:0] table_pointer;
      logic [7:0]  table_latch_byte;
   } emb_req_t;

   // Memory control settings
   typedef struct packed {
      logic       bus_8bit;
      logic       wait_enable;
      logic [1:0] wait_state_count;
      logic [1:0] write_mode_select;
   } emb_cfg_t;

   // Bus pin set
   typedef struct packed {
      logic [15:0] mux_bus_lines;
      logic [15:0] mux_bus_oe;
      logic        addr_valid;
      logic        chip_select_n;
      logic        read_enable_n;
      logic        write_high_strobe_n;
      logic        write_low_strobe_n;
      logic        upper_byte_select_n;
      logic        lower_byte_select_n;
      logic        byte_address_lsb;
   } emb_pins_t;
endpackage

// ===== hdl/emb_wait_timer.sv
`timescale 1ns/1ps
// ======================================================================
// Wait-state counter, counted in instruction cycles
// ======================================================================
module emb_wait_timer
   import emb_pkg::*;
(
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_n_in,
   input  wire logic             clk_en_in,
   // Control
   input  wire logic             load_in,
   input  wire logic [1:0]       count_in,
   input  wire logic             cycle_end_in,
   // Status
   output logic                  busy_out
);
   logic [1:0] remaining;

   // Load at end of a table cycle, count down per instruction cycle
   always_ff @(posedge clock_in)
   begin
      if (!rst_n_in)
         remaining <= 2'h0;
      else if (clk_en_in)
      begin
         if (load_in)
            remaining <= count_in;
         else if (cycle_end_in && remaining != 2'h0)
            remaining <= remaining - 2'h1;
      end
   end

   assign busy_out = (remaining != 2'h0);
endmodule // emb_wait_timer

// ===== test/emb_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// Word-wide SRAM on the multiplexed bus
// ==========================================
module emb_mem_model
   import emb_pkg::*;
(
   // Clock
   input  wire logic      clock_in,
   // Controller pins
   input  wire emb_pins_t pins_in,
   input  wire logic      bus_8bit_in,
   // Resolved level of the bus lines
   output logic [15:0]    bus_level_out
);
   logic [15:0] mem [0:32767];
   logic [15:0] addr_q = 16'h0000;
   logic [15:0] last_q = 16'h0000;
   logic [15:0] ea;
   logic [15:0] word;
   logic [15:0] rdv;
   logic        rd;

   // Preset contents so reads of unwritten words are predictable
   initial
   begin
      for (int i = 0; i < 32768; i++)
         mem[i] = 16'h5a00 ^ 16'(i);
   end

   // Read drive; an undriven line shows the inverse of its last level,
   // since no pull-up holds it and a stale value must not look valid
   always_comb
   begin
      ea = pins_in.addr_valid ? pins_in.mux_bus_lines : addr_q;
      word = mem[ea[15:1]];
      rdv = bus_8bit_in ? {2{pins_in.byte_address_lsb ? word[15:8] : word[7:0]}} : word;
      rd = !pins_in.chip_select_n && !pins_in.read_enable_n;
      bus_level_out = (pins_in.mux_bus_oe & pins_in.mux_bus_lines)
                    | (~pins_in.mux_bus_oe & (rd ? rdv : ~last_q));
   end

   // Address capture and byte-selected writes on the high strobe
   always @(posedge clock_in)
   begin
      last_q <= bus_level_out;
      if (pins_in.addr_valid)
         addr_q <= pins_in.mux_bus_lines;
      if (!pins_in.chip_select_n && !pins_in.write_high_strobe_n)
      begin
         if (bus_8bit_in && pins_in.byte_address_lsb)
            mem[ea[15:1]][15:8] <= pins_in.mux_bus_lines[7:0];
         else if (bus_8bit_in)
            mem[ea[15:1]][7:0] <= pins_in.mux_bus_lines[7:0];
         else
         begin
            if (!pins_in.upper_byte_select_n)
               mem[ea[15:1]][15:8] <= pins_in.mux_bus_lines[15:8];
            if (!pins_in.lower_byte_select_n)
               mem[ea[15:1]][7:0] <= pins_in.mux_bus_lines[7:0];
         end
      end
   end
endmodule // emb_mem_model

// ===== test/external_memory_bus_modes_bench.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the external memory bus controller
// ==========================================
module external_memory_bus_modes_bench;
   import emb_pkg::*;
   logic        clock_in;
   logic        rst_n_in;
   logic        clk_en_in;
   logic        req_valid_in;
   emb_req_t    req_in;
   logic        req_ready_out;
   logic        rd_valid_out;
   logic [15:0] rd_data_out;
   emb_cfg_t    cfg_in;
   logic        sleep_in;
   logic        idle_in;
   logic [15:0] mux_bus_in;
   emb_pins_t   pins_out;
   emb_pins_t   tr [0:5];
   emb_pins_t   ps;
   emb_pins_t   q;
   logic [15:0] rd_got;
   logic        slow, en_seen, oe_data, ba_lo, ba_hi, lo_float;
   int          fail_count, cmp_count, t_av, rd_k, nwh, nwl;
   int          cyc = 0;
   int          iv [0:3];

   emb_bus_ctrl dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
      .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
      .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .cfg_in(cfg_in),
      .sleep_in(sleep_in), .idle_in(idle_in), .mux_bus_in(mux_bus_in), .pins_out(pins_out));
   emb_mem_model mem_i (.clock_in(clock_in), .pins_in(pins_out),
      .bus_8bit_in(cfg_in.bus_8bit), .bus_level_out(mux_bus_in));

   // ==========================================
   // Clock, enable pattern, cycle ceiling
   // ==========================================
   initial
   begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   // Slow run mode enables every other edge
   always @(negedge clock_in)
      clk_en_in <= slow ? ~clk_en_in : 1'b1;

   always @(posedge clock_in)
      en_seen <= clk_en_in;

   // A hang ends the run well past the expected few hundred cycles
   always @(posedge clock_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 8000)
      begin
         fail_count++;
         $display("mismatch at %0t: run did not finish", $time);
         finish_test;
      end
   end

   // ==========================================
   // Tasks
   // ==========================================
   task automatic chk(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One table access; traces pins over six enabled cycles from address valid, or one when stop is set
   task automatic access(input logic wr, input logic [15:0] ptr, input logic [7:0] dat,
                         input logic stop);
      int k;
      int n;
      k = 0;
      n = 0;
      rd_k = -1;
      rd_got = 16'h0000;
      nwh = 0;
      nwl = 0;
      {oe_data, ba_lo, ba_hi, lo_float} = 4'h0;
      req_in = {wr, ptr, dat};
      req_valid_in = 1'b1;
      while (k < (stop ? 1 : 6) && n < 400)
      begin
         @(negedge clock_in);
         n++;
         if (en_seen && (k > 0 || pins_out.addr_valid === 1'b1))
         begin
            tr[k] = pins_out;
            req_valid_in = 1'b0;
            if (k == 0)
               t_av = cyc;
            if (rd_valid_out === 1'b1)
               rd_k = k;
            if (rd_valid_out === 1'b1)
               rd_got = rd_data_out;
            if (pins_out.write_high_strobe_n === 1'b0)
               nwh++;
            if (pins_out.write_high_strobe_n === 1'b0)
               ps = pins_out;
            if (pins_out.write_low_strobe_n === 1'b0)
               nwl++;
            if (k >= 1 && k <= 3 && pins_out.mux_bus_oe !== 16'h0000)
               oe_data = 1'b1;
            if (pins_out.read_enable_n === 1'b0)
            begin
               ba_hi = ba_hi | (ba_lo & pins_out.byte_address_lsb === 1'b1);
               ba_lo = ba_lo | (pins_out.byte_address_lsb === 1'b0);
               lo_float = lo_float | (pins_out.mux_bus_oe[7:0] === 8'h00);
            end
            k++;
         end
      end
      chk(k == (stop ? 1 : 6), "access never started");
      chk(tr[0].mux_bus_lines === ptr && tr[0].mux_bus_oe === 16'hffff, "address phase");
      chk(tr[0].chip_select_n === 1'b0, "chip select not low in access");
      if (!stop)
         chk(tr[4].chip_select_n === 1'b1, "chip select not released");
   endtask

   // ==========================================
   // Test sequence
   // ==========================================
   initial
   begin
      int t0;
      int n;
      {rst_n_in, req_valid_in, sleep_in, idle_in, slow} = 5'h00;
      req_in = '0;
      cfg_in = {1'b0, 1'b0, 2'h0, WM_WORD_WRITE};
      fail_count = 0;
      cmp_count = 0;
      repeat (12) @(negedge clock_in);
      rst_n_in = 1'b1;
      @(negedge clock_in);

      // Word write pairs and the holding latch
      access(1'b1, 16'h0120, 8'h11, 1'b0);
      chk(nwh === 0 && oe_data === 1'b0, "even word write drove the bus");
      chk(tr[1].byte_address_lsb === 1'b0, "even byte address");
      access(1'b1, 16'h0121, 8'h22, 1'b0);
      chk(nwh === 1 && ps.mux_bus_lines === 16'h2211, "odd word write data");
      chk(nwl === 0 && {ps.upper_byte_select_n, ps.lower_byte_select_n} === 2'h0, "selects");
      chk(ps.byte_address_lsb === 1'b1, "odd byte address");
      chk(mem_i.mem[16'h0090] === 16'h2211, "word not stored");
      access(1'b1, 16'h0123, 8'h44, 1'b0);
      chk(ps.mux_bus_lines === 16'h4411, "held byte lost");
      access(1'b0, 16'h0120, 8'h00, 1'b0);
      chk(rd_k === 5 && rd_got === 16'h2211, "word read back");
      end_test("word write");

      // Byte select writes, both byte lanes
      cfg_in.write_mode_select = WM_BYTE_SELECT;
      for (int b = 0; b < 2; b++)
      begin
         access(1'b1, 16'h0200 | 16'(b), 8'h5c + 8'(b), 1'b0);
         chk(nwh === 1 && nwl === 0 && ps.mux_bus_lines === {2{8'h5c + 8'(b)}}, "lanes");
         chk({ps.byte_address_lsb, ps.upper_byte_select_n, ps.lower_byte_select_n}
             === {b[0], !b[0], b[0]}, "byte select lines");
      end
      chk(mem_i.mem[16'h0100] === 16'h5d5c, "byte merge");
      end_test("byte select");

      // Eight-bit multiplexed bus
      cfg_in.bus_8bit = 1'b1;
      access(1'b1, 16'h0301, 8'h77, 1'b0);
      chk(ps.mux_bus_lines === 16'h7777 && ps.byte_address_lsb === 1'b1, "8-bit write");
      access(1'b0, 16'h0300, 8'h00, 1'b0);
      chk(ba_hi === 1'b1, "byte address did not step in read");
      chk(lo_float === 1'b1, "low lines not released for data");
      chk(rd_k === 5, "two-byte fetch overran one cycle");
      chk(rd_got === 16'h7780, "8-bit word assembly");
      cfg_in.bus_8bit = 1'b0;
      end_test("eight bit");

      // Wait states lengthen spacing by whole instruction cycles
      cfg_in.write_mode_select = WM_WORD_WRITE;
      cfg_in.wait_enable = 1'b1;
      for (int w = 0; w < 4; w++)
      begin
         cfg_in.wait_state_count = 2'(w);
         access(1'b0, 16'h0400, 8'h00, 1'b0);
         t0 = t_av;
         access(1'b0, 16'h0402, 8'h00, 1'b0);
         iv[w] = t_av - t0;
         chk(iv[w] - iv[0] === 4 * w && rd_got === 16'h5801, "wait spacing");
      end
      cfg_in.wait_enable = 1'b0;
      end_test("wait states");

      // Slow clock enable keeps the same cycle structure
      slow = 1'b1;
      access(1'b0, 16'h0404, 8'h00, 1'b0);
      chk(rd_k === 5 && rd_got === 16'h5802, "slow run read");
      slow = 1'b0;
      end_test("slow run");

      // Sleep then idle, entered in mid-access
      for (int s = 0; s < 2; s++)
      begin
         access(1'b0, 16'h0406, 8'h00, 1'b1);
         sleep_in = (s == 0);
         idle_in = (s == 1);
         ps = pins_out;
         for (int j = 0; j < 6; j++)
         begin
            @(negedge clock_in);
            q = pins_out;
            {q.chip_select_n, q.upper_byte_select_n, q.lower_byte_select_n} =
               {ps.chip_select_n, ps.upper_byte_select_n, ps.lower_byte_select_n};
            chk(q === ps, "bus not frozen");
            if (j > 0)
               chk({pins_out.chip_select_n, pins_out.upper_byte_select_n,
                    pins_out.lower_byte_select_n} === 3'h7, "selects not high");
         end
         sleep_in = 1'b0;
         idle_in = 1'b0;
         n = 0;
         while (req_ready_out !== 1'b1 && n < 50)
         begin
            @(negedge clock_in);
            n++;
         end
         chk(req_ready_out === 1'b1, "no recovery after wake");
      end
      end_test("low power");
      finish_test;
   end
endmodule // external_memory_bus_modes_bench
